// file: core/psol_latch.sv
// Strap option latch with APB access to control and advertisement bits.
// Assumes strap pins are board-pulled and stable while reset is held.
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/1ps
module psol_latch #(
	parameter int SYNC_STAGES = 2
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire psol_pkg::psol_straps_t strap_pins,
	input wire logic [psol_pkg::PHY_ADDR_W-1:0] mgmt_phy_addr,
	output logic addr_match,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [psol_pkg::ADDR_W-1:0] paddr,
	input wire logic [psol_pkg::DATA_W-1:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [psol_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic isolate_en,
	output logic speed_100,
	output logic aneg_en,
	output logic full_duplex,
	output logic [3:0] adv_ability,
	output logic nand_tree_mode,
	output logic bcast_off,
	output logic [psol_pkg::PHY_ADDR_W-1:0] phy_addr,
	output logic straps_loaded
);

	// Refuse a synchroniser that is too shallow
	if (SYNC_STAGES < psol_pkg::SYNC_MIN) begin : g_bad_sync
		$error("psol_latch: SYNC_STAGES below minimum");
	end

	// Byte lane merge below serves a 16-bit register only
	if (psol_pkg::REG_W != 16) begin : g_bad_width
		$error("psol_latch: REG_W must be 16");
	end

	psol_pkg::psol_straps_t strap_q;
	psol_pkg::psol_state_t state_r;
	psol_pkg::psol_state_t state_nxt;
	psol_pkg::psol_cfg_t cfg_r;
	psol_pkg::psol_cfg_t cfg_nxt;
	logic [psol_pkg::REG_W-1:0] ctrl_r;
	logic [psol_pkg::REG_W-1:0] ctrl_nxt;
	logic [psol_pkg::REG_W-1:0] adv_r;
	logic [psol_pkg::REG_W-1:0] adv_nxt;
	logic [psol_pkg::DATA_W-1:0] prdata_r;
	logic [psol_pkg::DATA_W-1:0] prdata_nxt;
	logic pslverr_r;
	logic pslverr_nxt;
	logic ready_r;

	// Strap levels cross into the core clock domain
	psol_sync #(
		.WIDTH($bits(psol_pkg::psol_straps_t)),
		.STAGES(SYNC_STAGES)
	) u_sync (
		.core_clk(core_clk),
		.async_in(strap_pins),
		.sync_out(strap_q)
	);

	// Byte lane merge for a 16-bit register
	function automatic logic [psol_pkg::REG_W-1:0] lane_merge(
		input logic [psol_pkg::REG_W-1:0] old_v,
		input logic [psol_pkg::DATA_W-1:0] wd,
		input logic [3:0] strb,
		input logic [psol_pkg::REG_W-1:0] mask
	);
		logic [psol_pkg::REG_W-1:0] v;
		v = old_v;
		if (strb[0]) begin
			v[7:0] = wd[7:0];
		end
		if (strb[1]) begin
			v[15:8] = wd[15:8];
		end
		return (v & mask) | (old_v & ~mask);
	endfunction : lane_merge

	// Strap decode for the load cycle
	wire load_now = (state_r == psol_pkg::ST_WAIT);
	wire strap_full = ~strap_q.duplex; // R5
	wire strap_nand = ~strap_q.nand_tree_n; // R11
	wire [psol_pkg::PHY_ADDR_W-1:0] strap_addr = {psol_pkg::PHY_ADDR_HI, strap_q.addr}; // R12

	// Control value built from straps
	logic [psol_pkg::REG_W-1:0] ctrl_load;
	always_comb begin
		ctrl_load = '0;
		ctrl_load[psol_pkg::CTRL_ISO] = strap_q.isolate; // R1 R2
		ctrl_load[psol_pkg::CTRL_SPEED] = strap_q.speed; // R3
		ctrl_load[psol_pkg::CTRL_ANEG] = strap_q.aneg; // R7 R8
		ctrl_load[psol_pkg::CTRL_DUPLEX] = strap_full; // R6
	end

	// Advertisement value built from straps
	logic [psol_pkg::REG_W-1:0] adv_load;
	always_comb begin
		adv_load = psol_pkg::ADV_RST;
		if (!strap_q.speed) begin
			adv_load[psol_pkg::ADV_100FD] = 1'b0; // R4
			adv_load[psol_pkg::ADV_100HD] = 1'b0; // R4
		end
	end

	// APB decode; the bus waits until the straps are loaded
	wire apb_acc = psel && penable && pready;
	wire hit_ctrl = (paddr == psol_pkg::OFS_CTRL);
	wire hit_adv = (paddr == psol_pkg::OFS_ADV);
	wire hit_cfg = (paddr == psol_pkg::OFS_CFG);
	wire hit_any = hit_ctrl || hit_adv || hit_cfg;
	wire wr_ctrl = apb_acc && pwrite && hit_ctrl;
	wire wr_adv = apb_acc && pwrite && hit_adv;
	// Capture in setup and in every wait state, so the answer is fresh
	wire bus_cap = psel && !(penable && pready);

	// Configuration readback word
	logic [psol_pkg::REG_W-1:0] cfg_word;
	always_comb begin
		cfg_word = '0;
		cfg_word[psol_pkg::PHY_ADDR_W-1:0] = cfg_r.phy_addr;
		cfg_word[psol_pkg::CFG_BCAST_OFF] = cfg_r.bcast_off;
		cfg_word[psol_pkg::CFG_NAND] = cfg_r.nand_tree_en;
		cfg_word[psol_pkg::CFG_LOADED] = (state_r == psol_pkg::ST_RUN);
	end

	// Read data selection
	wire [psol_pkg::REG_W-1:0] rd_sel =
		hit_ctrl ? ctrl_r :
		hit_adv ? adv_r :
		hit_cfg ? cfg_word : '0;

	// Next-state for loader and registers
	always_comb begin
		state_nxt = state_r;
		cfg_nxt = cfg_r;
		ctrl_nxt = ctrl_r;
		adv_nxt = adv_r;
		unique case (state_r)
			psol_pkg::ST_WAIT: begin
				// First edge out of reset takes the straps, once
				state_nxt = psol_pkg::ST_RUN; // R13
				cfg_nxt.bcast_off = strap_q.bcast_off; // R9 R10
				cfg_nxt.nand_tree_en = strap_nand; // R11
				cfg_nxt.phy_addr = strap_addr; // R12
				ctrl_nxt = ctrl_load;
				adv_nxt = adv_load;
			end
			psol_pkg::ST_RUN: begin
				// Software may change writable bits later
				if (wr_ctrl) begin
					ctrl_nxt = lane_merge(ctrl_r, pwdata, pstrb, psol_pkg::CTRL_WMASK); // R13
				end
				if (wr_adv) begin
					adv_nxt = lane_merge(adv_r, pwdata, pstrb, psol_pkg::ADV_WMASK);
				end
			end
		endcase
	end

	// Read data and error capture
	always_comb begin
		prdata_nxt = prdata_r;
		pslverr_nxt = 1'b0;
		if (bus_cap) begin
			prdata_nxt = pwrite ? '0 : {16'h0000, rd_sel};
			pslverr_nxt = !hit_any;
		end
	end

	// Loader state and held settings
	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_r <= psol_pkg::ST_WAIT;
			cfg_r <= '{bcast_off: 1'b0, nand_tree_en: 1'b0,
				phy_addr: psol_pkg::PHY_ADDR_RST};
		end else begin
			state_r <= state_nxt;
			cfg_r <= cfg_nxt;
		end
	end

	// Control and advertisement registers
	always_ff @(posedge core_clk) begin
		if (reset) begin
			ctrl_r <= psol_pkg::CTRL_RST;
			adv_r <= psol_pkg::ADV_RST;
		end else begin
			ctrl_r <= ctrl_nxt;
			adv_r <= adv_nxt;
		end
	end

	// Bus answer registers; ready trails the load so a read never sees reset values
	always_ff @(posedge core_clk) begin
		if (reset) begin
			prdata_r <= '0;
			pslverr_r <= 1'b0;
			ready_r <= 1'b0;
		end else begin
			prdata_r <= prdata_nxt;
			pslverr_r <= pslverr_nxt;
			ready_r <= (state_r == psol_pkg::ST_RUN);
		end
	end

	// Management address match
	wire addr_is_zero = (mgmt_phy_addr == '0);
	wire own_match = (mgmt_phy_addr == cfg_r.phy_addr);
	wire bcast_hit = addr_is_zero && !cfg_r.bcast_off; // R9
	assign addr_match = straps_loaded && (own_match || bcast_hit); // R10

	// Outputs from registers
	assign pready = ready_r; // One cycle after the load
	assign prdata = prdata_r;
	assign pslverr = pslverr_r && psel && penable;
	assign isolate_en = ctrl_r[psol_pkg::CTRL_ISO];
	assign speed_100 = ctrl_r[psol_pkg::CTRL_SPEED];
	assign aneg_en = ctrl_r[psol_pkg::CTRL_ANEG];
	assign full_duplex = ctrl_r[psol_pkg::CTRL_DUPLEX];
	assign adv_ability = adv_r[psol_pkg::ADV_100FD:psol_pkg::ADV_100FD-3];
	assign nand_tree_mode = cfg_r.nand_tree_en;
	assign bcast_off = cfg_r.bcast_off;
	assign phy_addr = cfg_r.phy_addr;
	assign straps_loaded = (state_r == psol_pkg::ST_RUN);

	// Checks on the load and the held settings
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (reset);

	isolate_load_a: assert property ( // R1
		load_now |=> isolate_en == $past(strap_q.isolate))
		else $error("isolate bit not loaded from strap");

	isolate_dflt_a: assert property ( // R2
		load_now && !strap_q.isolate |=> !isolate_en [*2])
		else $error("isolate set with low strap");

	speed_load_a: assert property ( // R3
		load_now |=> speed_100 == $past(strap_q.speed))
		else $error("speed bit not loaded from strap");

	adv_speed_a: assert property ( // R4
		load_now && !strap_q.speed |=> adv_ability[3:2] == 2'h0)
		else $error("100Mbps advertised with low speed strap");

	duplex_sense_a: assert property ( // R5
		load_now && strap_q.duplex |=> !full_duplex)
		else $error("full duplex with high duplex strap");

	duplex_load_a: assert property ( // R6
		load_now |=> full_duplex != $past(strap_q.duplex))
		else $error("duplex bit not loaded from strap");

	aneg_load_a: assert property ( // R8
		load_now |=> aneg_en == $past(strap_q.aneg))
		else $error("autoneg bit not loaded from strap");

	bcast_match_a: assert property ( // R9
		straps_loaded && !bcast_off && mgmt_phy_addr == 5'h00 |-> addr_match)
		else $error("broadcast address 0 not answered");

	unique_zero_a: assert property ( // R10
		straps_loaded && bcast_off && mgmt_phy_addr == 5'h00
		|-> addr_match == (phy_addr == 5'h00))
		else $error("address 0 matched while unique");

	nand_mode_a: assert property ( // R11
		load_now |=> nand_tree_mode == !$past(strap_q.nand_tree_n))
		else $error("NAND-tree mode not loaded from strap");

	phy_addr_a: assert property ( // R12
		load_now |=> phy_addr == {2'h0, $past(strap_q.addr)})
		else $error("PHY address not loaded from straps");

	cfg_hold_a: assert property ( // R13
		straps_loaded |=> $stable(cfg_r) && straps_loaded)
		else $error("strap settings changed after load");

	// Further load checks
	iso_on_a: assert property ( // R1
		load_now && strap_q.isolate |=> isolate_en)
		else $error("isolate not set with high strap");

	adv_full_a: assert property ( // R4
		load_now && strap_q.speed |=> adv_ability == 4'hF)
		else $error("full advertisement not loaded with high speed strap");

	aneg_sense_a: assert property ( // R7
		load_now && !strap_q.aneg |=> !aneg_en)
		else $error("autoneg enabled with low strap");

	bcast_load_a: assert property ( // R10
		load_now |=> bcast_off == $past(strap_q.bcast_off))
		else $error("broadcast-off setting not loaded from strap");

	nand_sense_a: assert property ( // R11
		load_now && strap_q.nand_tree_n |=> !nand_tree_mode)
		else $error("NAND-tree mode with high strap");

	addr_high_a: assert property ( // R12
		straps_loaded |-> phy_addr[4:3] == 2'h0)
		else $error("upper PHY address bits not zero");

	match_pre_a: assert property ( // R12
		!straps_loaded |-> !addr_match)
		else $error("address matched before straps loaded");

	// Checks on what software may change after the load, and on bus readiness
	ctrl_hold_a: assert property ( // R13
		straps_loaded && !wr_ctrl |=> $stable(ctrl_r))
		else $error("control changed without a write");

	adv_hold_a: assert property ( // R13
		straps_loaded && !wr_adv |=> $stable(adv_r))
		else $error("advertisement changed without a write");

	ctrl_ro_a: assert property ( // R13
		wr_ctrl |=> (ctrl_r & ~psol_pkg::CTRL_WMASK)
		== ($past(ctrl_r) & ~psol_pkg::CTRL_WMASK))
		else $error("read-only control bits written");

	adv_sel_a: assert property ( // R13
		straps_loaded |-> adv_r[4:0] == psol_pkg::ADV_SEL[4:0])
		else $error("advertisement selector changed");

	ready_wait_a: assert property ( // R13
		!straps_loaded |-> !pready)
		else $error("bus ready before straps loaded");

	ready_on_a: assert property ( // R13
		straps_loaded |=> pready)
		else $error("bus not ready after load");

	// Main scenarios
	slow_strap_c: cover property (load_now && !strap_q.speed);
	ready_wait_c: cover property (psel && !pready);
	bcast_hit_c: cover property (addr_match && mgmt_phy_addr == 5'h00);
	ctrl_write_c: cover property (wr_ctrl ##1 speed_100 == 1'b0);
	unmapped_c: cover property (pslverr);

endmodule : psol_latch

// file: core/psol_sync.sv
// Multi-stage level synchroniser for board-driven pins.
// Assumes slowly changing levels; no reset so it tracks pins during reset.
`timescale 1ns/1ps
module psol_sync #(
	parameter int WIDTH = 1,
	parameter int STAGES = 2
) (
	input wire logic core_clk,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage_r [STAGES];

	// Refuse depths that cannot synchronise
	if (STAGES < psol_pkg::SYNC_MIN || WIDTH < 1) begin : g_bad_cfg
		$error("psol_sync: bad STAGES or WIDTH");
	end

	// Shift chain; only the next stage reads each flop, and only the output reads the last
	always_ff @(posedge core_clk) begin
		stage_r[0] <= async_in;
		for (int i = 1; i < STAGES; i++) begin
			stage_r[i] <= stage_r[i-1];
		end
	end

	assign sync_out = stage_r[STAGES-1];

endmodule : psol_sync

// file: include/psol_pkg.sv
// Constants, carriers and field layout for the strap option latch.
// Assumes one 200 MHz core clock and a synchronous active-high reset.
// Contract
// R1 - Isolate strap loads control bit 10
// R2 - Isolate defaults disabled through pull-down
// R3 - Speed strap loads control bit 13
// R4 - Low speed strap limits advertisement to 10Mbps
// R5 - Duplex strap high half, low full
// R6 - Duplex strap loads control bit 8
// R7 - Autoneg strap high enables, low disables
// R8 - Autoneg strap loads control bit 12
// R9 - Broadcast-off low: address 0 always answers
// R10 - Broadcast-off high: address 0 is unique
// R11 - NAND-tree strap low enables test mode
// R12 - Address straps give 0 to 7, upper bits 00
// R13 - Straps sampled once; settings hold until reset
package psol_pkg;

	// Bus geometry
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int REG_W = 16;
	localparam int PHY_ADDR_W = 5;
	localparam int STRAP_ADDR_W = 3;

	// Register byte addresses
	localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h000;
	localparam logic [ADDR_W-1:0] OFS_ADV = 12'h004;
	localparam logic [ADDR_W-1:0] OFS_CFG = 12'h008;

	// Control register fields
	localparam int CTRL_SPEED = 13;
	localparam int CTRL_ANEG = 12;
	localparam int CTRL_ISO = 10;
	localparam int CTRL_DUPLEX = 8;
	localparam logic [REG_W-1:0] CTRL_WMASK = 16'h3500;
	localparam logic [REG_W-1:0] CTRL_RST = 16'h3000;

	// Advertisement register fields
	localparam int ADV_100FD = 8;
	localparam int ADV_100HD = 7;
	localparam logic [REG_W-1:0] ADV_WMASK = 16'h01E0;
	localparam logic [REG_W-1:0] ADV_SEL = 16'h0001;
	localparam logic [REG_W-1:0] ADV_RST = 16'h01E1;

	// Configuration readback fields
	localparam int CFG_BCAST_OFF = 5;
	localparam int CFG_NAND = 6;
	localparam int CFG_LOADED = 7;

	// Internal pull levels of the strap pins
	localparam logic [PHY_ADDR_W-1:0] PHY_ADDR_RST = 5'h01;
	localparam logic [1:0] PHY_ADDR_HI = 2'h0;

	// Minimum synchroniser depth
	localparam int SYNC_MIN = 2;

	// Strap pin levels as sampled
	typedef struct packed {
		logic isolate;
		logic speed;
		logic duplex;
		logic aneg;
		logic bcast_off;
		logic nand_tree_n;
		logic [STRAP_ADDR_W-1:0] addr;
	} psol_straps_t;

	// Settings kept until the next reset
	typedef struct packed {
		logic bcast_off;
		logic nand_tree_en;
		logic [PHY_ADDR_W-1:0] phy_addr;
	} psol_cfg_t;

	// Loader state
	typedef enum logic [0:0] {
		ST_WAIT = 1'b0,
		ST_RUN = 1'b1
	} psol_state_t;

endpackage : psol_pkg

// file: test/phy_strap_option_latch_tb.sv
// Self-checking bench for the strap option latch.
// Assumes zero-wait APB once straps load; board model drives the pins.
`timescale 1ns/1ps
module phy_strap_option_latch_tb;
	logic core_clk, reset, psel, penable, pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb, adv_ability;
	logic pready, pslverr, addr_match, isolate_en, speed_100, aneg_en, full_duplex, err;
	logic nand_tree_mode, bcast_off, straps_loaded;
	logic [4:0] mgmt_phy_addr, phy_addr;
	logic [8:0] fit_en, fit_lvl;
	psol_pkg::psol_straps_t strap_pins;
	int miscompares = 0;
	int n_checks = 0;

	// Board and device
	psol_strap_board u_board (.fit_en, .fit_lvl, .strap_pins);
	psol_latch u_dut (.core_clk, .reset, .strap_pins, .mgmt_phy_addr, .addr_match, .psel,
		.penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .isolate_en,
		.speed_100, .aneg_en, .full_duplex, .adv_ability, .nand_tree_mode, .bcast_off,
		.phy_addr, .straps_loaded);

	// Clock
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// One APB transfer, waiting on pready under a bound
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 200);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 200) miscompares++;
	endtask : apb

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
		chk({31'h0, err}, 32'h0);
	endtask : rd_chk

	task automatic mt(input logic [4:0] a, input logic e);
		@(posedge core_clk);
		mgmt_phy_addr <= a;
		#1 chk({31'h0, addr_match}, {31'h0, e});
	endtask : mt

	task automatic do_reset(input logic [8:0] en, input logic [8:0] lvl);
		@(posedge core_clk);
		reset <= 1'b1;
		fit_en <= en;
		fit_lvl <= lvl;
		repeat (10) @(posedge core_clk);
		reset <= 1'b0;
	endtask : do_reset

	task automatic t_defaults;
		do_reset(9'h000, 9'h000);
		rd_chk(psol_pkg::OFS_CTRL, 32'h0000_3000);
		rd_chk(psol_pkg::OFS_ADV, 32'h0000_01E1);
		rd_chk(psol_pkg::OFS_CFG, 32'h0000_0081);
		chk({28'h0, isolate_en, speed_100, aneg_en, full_duplex}, 32'h6);
		chk({21'h0, straps_loaded, adv_ability, bcast_off, phy_addr}, 32'h7C1);
		mt(5'h00, 1'b1);
		mt(5'h01, 1'b1);
		mt(5'h02, 1'b0);
		$display("test defaults done");
	endtask : t_defaults

	task automatic t_inverted;
		do_reset(9'h1FF, 9'h117);
		rd_chk(psol_pkg::OFS_CTRL, 32'h0000_0500);
		rd_chk(psol_pkg::OFS_ADV, 32'h0000_0061);
		rd_chk(psol_pkg::OFS_CFG, 32'h0000_00E7);
		chk({27'h0, isolate_en, speed_100, aneg_en, full_duplex, nand_tree_mode}, 32'h13);
		chk({21'h0, straps_loaded, adv_ability, bcast_off, phy_addr}, 32'h4E7);
		mt(5'h00, 1'b0);
		mt(5'h07, 1'b1);
		$display("test inverted done");
	endtask : t_inverted

	task automatic t_unique_hold;
		do_reset(9'h017, 9'h010);
		mt(5'h00, 1'b1);
		mt(5'h01, 1'b0);
		@(posedge core_clk);
		fit_en <= 9'h1FF;
		fit_lvl <= 9'h000;
		repeat (6) @(posedge core_clk);
		rd_chk(psol_pkg::OFS_CFG, 32'h0000_00A0);
		rd_chk(psol_pkg::OFS_CTRL, 32'h0000_3000);
		chk({21'h0, straps_loaded, adv_ability, bcast_off, phy_addr}, 32'h7E0);
		apb(1'b1, psol_pkg::OFS_CTRL, 32'h0000_FFFF);
		rd_chk(psol_pkg::OFS_CTRL, 32'h0000_3500);
		chk({28'h0, isolate_en, speed_100, aneg_en, full_duplex}, 32'hF);
		apb(1'b1, psol_pkg::OFS_CTRL, 32'h0000_0000);
		rd_chk(psol_pkg::OFS_CTRL, 32'h0000_0000);
		apb(1'b1, psol_pkg::OFS_ADV, 32'h0000_0000);
		rd_chk(psol_pkg::OFS_ADV, 32'h0000_0001);
		chk({28'h0, adv_ability}, 32'h0);
		apb(1'b0, 12'h00C, 32'h0);
		chk({31'h0, err}, 32'h1);
		chk(rd, 32'h0);
		$display("test unique and hold done");
	endtask : t_unique_hold

	task automatic close_out;
		$display("checks=%0d mismatches=%0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : close_out

	// Watchdog well beyond the hundred or so cycles the tests need
	initial begin
		#20000;
		miscompares++;
		close_out();
	end

	// Main sequence
	initial begin
		reset = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'hF;
		mgmt_phy_addr = 5'h00;
		fit_en = 9'h000;
		fit_lvl = 9'h000;
		t_defaults();
		t_inverted();
		t_unique_hold();
		close_out();
	end
endmodule : phy_strap_option_latch_tb

// file: test/psol_strap_board.sv
// Board model for the strap pins: internal pulls with optional fitted resistors.
// Assumes the bench changes fitted resistors around a reset, or after the load to test that settings hold.
`timescale 1ns/1ps
module psol_strap_board (
	input wire logic [8:0] fit_en,
	input wire logic [8:0] fit_lvl,
	output psol_pkg::psol_straps_t strap_pins
);
	// Pull levels: iso down, speed up, duplex up, aneg up, bcast down, nand up, addr 001
	localparam logic [8:0] PULLS = 9'h0E9;
	// A fitted resistor overrides the internal pull
	assign strap_pins = (fit_en & fit_lvl) | (~fit_en & PULLS);
endmodule : psol_strap_board
